// *** rtl/dac_port_regs.vh ***
`ifndef DAC_PORT_REGS_VH
`define DAC_PORT_REGS_VH

// Destination select codes {hi, lo}
`define DEST_INPUT 2'b11
`define DEST_OFFSET 2'b10
`define DEST_GAIN 2'b01
`define DEST_SPECIAL 2'b00

// Instruction word layout, shared by the serial frame and the queue
`define INSTR_W 24
`define INSTR_DEST_HI 23
`define INSTR_DEST_LO 22
`define INSTR_ADDR_HI 21
`define INSTR_ADDR_LO 14
`define INSTR_DATA_HI 13
`define INSTR_DATA_LO 0

// Serial frame
`define FRAME_BITS 5'd24

// Instruction queue
`define QUEUE_DEPTH 7'd120
`define QUEUE_AW 7

// Channel organisation
`define CHANNEL_COUNT 6'd40
`define GROUP_COUNT 2'd3
`define GROUP_SIZE_LAST 4'd9

// Special function fields
`define STEP_DIR_BIT 8
`define STEP_MAG_HI 6
`define SOFT_RESET_CODE 14'h3fff

// Data limits
`define FULL_SCALE 14'h3fff
`define ZERO_SCALE 14'h0000

// Register defaults after soft reset
`define INPUT_RESET 14'h0000
`define OFFSET_RESET 14'h2000
`define GAIN_RESET 13'h1fff

`endif

// *** rtl/instr_queue.v ***
`timescale 1ns/100ps
`default_nettype none
`include "dac_port_regs.vh"

module instr_queue (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Fill side
	input wire push,
	input wire [`INSTR_W-1:0] push_word,
	output wire full,
	// Drain side
	input wire pop,
	output wire [`INSTR_W-1:0] head_word,
	output wire not_empty
);

	reg [`INSTR_W-1:0] store [0:119];
	reg [`QUEUE_AW-1:0] wr_ptr;
	reg [`QUEUE_AW-1:0] rd_ptr;
	reg [`QUEUE_AW-1:0] count;
	wire do_push;
	wire do_pop;

	assign full = (count == `QUEUE_DEPTH);
	assign not_empty = (count != 7'h00);
	// A push into a full queue is dropped
	assign do_push = push && !full; // (R3)
	assign do_pop = pop && not_empty;
	assign head_word = store[rd_ptr];

	always @(posedge clk_sys) begin
		if (do_push) begin
			store[wr_ptr] <= push_word; // (R2)
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 7'h00;
			rd_ptr <= 7'h00;
			count <= 7'h00;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == `QUEUE_DEPTH - 7'd1) ? 7'h00 : wr_ptr + 7'd1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == `QUEUE_DEPTH - 7'd1) ? 7'h00 : rd_ptr + 7'd1;
			end
			if (do_push && !do_pop) begin
				count <= count + 7'd1;
			end else if (do_pop && !do_push) begin
				count <= count - 7'd1;
			end
		end
	end

endmodule
`default_nettype wire

// *** rtl/serial_frame_rx.v ***
`timescale 1ns/100ps
`default_nettype none
`include "dac_port_regs.vh"

module serial_frame_rx (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Mode
	input wire enable,
	input wire chain_mode,
	// Serial pins, asynchronous
	input wire frame_sel_n,
	input wire shift_clk,
	input wire serial_din,
	// Results
	output reg frame_start,
	output reg word_valid,
	output reg [`INSTR_W-1:0] word,
	output reg chain_out_line
);

	reg [2:0] sync_a;
	reg [2:0] sync_b;
	reg frame_q;
	reg clk_q;
	reg active;
	reg [4:0] bit_count;
	reg [`INSTR_W-1:0] shifter;
	wire frame_now;
	wire clk_now;
	wire frame_fall;
	wire frame_rise;
	wire clk_fall;
	wire clk_rise;
	wire full_frame;

	// Second stage only is read; edge logic looks at third stage
	assign frame_now = sync_b[0];
	assign clk_now = sync_b[1];
	assign frame_fall = frame_q && !frame_now;
	assign frame_rise = !frame_q && frame_now;
	assign clk_fall = clk_q && !clk_now;
	assign clk_rise = !clk_q && clk_now;
	assign full_frame = (bit_count == `FRAME_BITS);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			frame_q <= 1'b1;
			clk_q <= 1'b1;
			active <= 1'b0;
			bit_count <= 5'h00;
			shifter <= 24'h00_0000;
			frame_start <= 1'b0;
			word_valid <= 1'b0;
			word <= 24'h00_0000;
			chain_out_line <= 1'b0;
		end else begin
			sync_a <= {serial_din, shift_clk, frame_sel_n};
			sync_b <= sync_a;
			frame_q <= frame_now;
			clk_q <= clk_now;
			frame_start <= 1'b0;
			word_valid <= 1'b0;
			if (!enable) begin
				active <= 1'b0;
				chain_out_line <= 1'b0;
			end else if (!chain_mode) begin
				// Output rests low whenever the chain is not in use
				chain_out_line <= 1'b0;
				// Standalone: mid-frame select edges are ignored
				if (frame_fall && (!active || full_frame)) begin // (R10) (R11)
					active <= 1'b1;
					bit_count <= 5'h00; // (R10)
					frame_start <= 1'b1; // (R5)
				end else if (active && !full_frame && clk_fall) begin // (R12)
					shifter <= {shifter[`INSTR_W-2:0], sync_b[2]}; // (R25)
					bit_count <= bit_count + 5'd1;
					if (bit_count == `FRAME_BITS - 5'd1) begin
						word <= {shifter[`INSTR_W-2:0], sync_b[2]};
						word_valid <= 1'b1;
					end
				end
			end else begin
				if (frame_fall) begin
					active <= 1'b1;
					bit_count <= 5'h00;
					frame_start <= 1'b1; // (R5)
				end else if (active && !frame_now && clk_fall) begin
					shifter <= {shifter[`INSTR_W-2:0], sync_b[2]}; // (R14)
					if (!full_frame) begin
						bit_count <= bit_count + 5'd1;
					end
				end else if (active && frame_rise) begin
					// Frame end latches the word and halts shifting
					active <= 1'b0; // (R17)
					if (full_frame) begin
						word <= shifter; // (R17)
						word_valid <= 1'b1;
					end // (R16)
				end
				// Changes on the rising edge, stable for the next falling sample
				if (active && clk_rise) begin
					chain_out_line <= shifter[`INSTR_W-1]; // (R14) (R15)
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** rtl/dac_host_write_port.v ***
// How it works
// (R1) Port choice pin selects serial or parallel
// (R2) Queue up to 120 instructions while executing
// (R3) Drop writes arriving when queue full
// (R4) Busy low while queued instructions execute
// (R5) Strobe or frame falling edge wakes port
// (R6) Load strobe rise with select captures instruction
// (R7) Two select bits pick register type
// (R8) Data is straight binary, top line MSB
// (R9) Address picks groups and register within
// (R10) Frame fall starts write, clears bit counter
// (R11) Standalone ignores frame edges mid-frame
// (R12) After 24 bits standalone ignores shift clock
// (R13) Chain enable picks standalone or chain
// (R14) Chain mode shifts always; overflow leaves output
// (R15) Chain output changes on shift clock rise
// (R16) Host sends 24N clocks; short frame dropped
// (R17) Frame rise latches word, stops shifting
// (R18) Host times frame select to clock count
// (R19) Offset is offset binary, midpoint zero
// (R20) Gain uses upper 13 data bits
// (R21) Special write steps input by 7-bit magnitude
// (R22) All-ones special write performs soft reset
// (R23) Direction bit high increments, low decrements
// (R24) Steps clamp at full and zero scale
// (R25) Serial frame is MSB first, select-address-data
`timescale 1ns/100ps
`default_nettype none
`include "dac_port_regs.vh"

module dac_host_write_port (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Mode pins
	input wire port_choice_pin,
	input wire chain_enable_pin,
	// Parallel port
	input wire device_select_n,
	input wire load_strobe_n,
	input wire dest_select_hi,
	input wire dest_select_lo,
	input wire [7:0] channel_address_lines,
	input wire [13:0] data_word_lines,
	// Serial port
	input wire frame_sel_n,
	input wire shift_clk,
	input wire serial_din,
	output wire chain_out_line,
	// Status
	output reg busy_n,
	output reg interface_awake,
	output reg queue_full,
	// Register write results
	output reg reg_write,
	output reg [5:0] reg_channel,
	output reg [1:0] reg_kind,
	output reg [13:0] reg_value,
	output reg outputs_to_ground_sense
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	// Pin synchronisers
	reg [1:0] mode_a;
	reg [1:0] mode_b;
	reg [1:0] strobe_a;
	reg [1:0] strobe_b;
	reg strobe_q;
	reg [23:0] par_a;
	reg [23:0] par_b;

	// Channel register files
	reg [13:0] input_mem [0:39];
	reg [13:0] offset_mem [0:39];
	reg [12:0] gain_mem [0:39];

	// Executor
	reg state;
	reg [`INSTR_W-1:0] instr;
	reg [5:0] chan;
	reg [1:0] grp;
	reg [3:0] idx;
	reg next_state;

	wire serial_mode;
	wire chain_mode;
	wire strobe_fall;
	wire strobe_rise;
	wire par_push;
	wire ser_start;
	wire ser_valid;
	wire [`INSTR_W-1:0] ser_word;
	wire q_full;
	wire q_not_empty;
	wire [`INSTR_W-1:0] q_head;
	wire q_pop;
	wire push;
	wire [`INSTR_W-1:0] push_word;
	wire [1:0] dest;
	wire [7:0] addr;
	wire [13:0] data;
	wire all_groups;
	wire chan_hit;
	wire soft_reset;
	wire last_chan;
	wire [6:0] step_mag;
	wire [14:0] step_up;
	wire [13:0] step_value;
	wire [13:0] cur_input;

	assign serial_mode = mode_b[0]; // (R1)
	assign chain_mode = mode_b[1]; // (R13)
	assign strobe_fall = strobe_q && !strobe_b[0];
	assign strobe_rise = !strobe_q && strobe_b[0];
	// Select is sampled with the strobe; both arrive through equal stages
	assign par_push = !serial_mode && strobe_rise && !strobe_b[1]; // (R1) (R6)
	assign push = par_push || ser_valid;
	assign push_word = par_push ? par_b : ser_word;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_a <= 2'b00;
			mode_b <= 2'b00;
			strobe_a <= 2'b11;
			strobe_b <= 2'b11;
			strobe_q <= 1'b1;
			par_a <= 24'h00_0000;
			par_b <= 24'h00_0000;
		end else begin
			mode_a <= {chain_enable_pin, port_choice_pin};
			mode_b <= mode_a;
			strobe_a <= {device_select_n, load_strobe_n};
			strobe_b <= strobe_a;
			strobe_q <= strobe_b[0];
			// Bus lines settle well before the strobe edge is seen here
			par_a <= {dest_select_hi, dest_select_lo, channel_address_lines,
				data_word_lines}; // (R8)
			par_b <= par_a;
		end
	end

	serial_frame_rx u_serial (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.enable(serial_mode),
		.chain_mode(chain_mode),
		.frame_sel_n(frame_sel_n),
		.shift_clk(shift_clk),
		.serial_din(serial_din),
		.frame_start(ser_start),
		.word_valid(ser_valid),
		.word(ser_word),
		.chain_out_line(chain_out_line)
	);

	instr_queue u_queue (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(push), // (R2)
		.push_word(push_word),
		.full(q_full),
		.pop(q_pop),
		.head_word(q_head),
		.not_empty(q_not_empty)
	);

	// Decode of the instruction being executed
	assign dest = instr[`INSTR_DEST_HI:`INSTR_DEST_LO];
	assign addr = instr[`INSTR_ADDR_HI:`INSTR_ADDR_LO];
	assign data = instr[`INSTR_DATA_HI:`INSTR_DATA_LO];
	assign all_groups = (addr[7:4] == 4'h0);
	// Register indices above nine match no channel when any group bit is set
	assign chan_hit = all_groups || (addr[4 + grp] && addr[3:0] == idx); // (R9)
	assign soft_reset = (dest == `DEST_SPECIAL) && (data == `SOFT_RESET_CODE); // (R22)
	assign last_chan = (chan == `CHANNEL_COUNT - 6'd1);
	assign q_pop = (state == ST_IDLE) && q_not_empty;

	// Step arithmetic with clamping, no wrap
	assign cur_input = input_mem[chan];
	assign step_mag = data[`STEP_MAG_HI:0]; // (R21)
	assign step_up = {1'b0, cur_input} + {8'h00, step_mag};
	assign step_value = data[`STEP_DIR_BIT] ? // (R23)
		(step_up[14] ? `FULL_SCALE : step_up[13:0]) : // (R24)
		((cur_input < {7'h00, step_mag}) ? `ZERO_SCALE : // (R24)
		cur_input - {7'h00, step_mag});

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (q_not_empty) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (last_chan) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Array contents are not reset; soft reset rewrites them in one pass
	always @(posedge clk_sys) begin
		if (state == ST_RUN) begin
			if (soft_reset) begin
				input_mem[chan] <= `INPUT_RESET; // (R22)
				offset_mem[chan] <= `OFFSET_RESET;
				gain_mem[chan] <= `GAIN_RESET;
			end else if (chan_hit) begin
				case (dest) // (R7)
					`DEST_INPUT: input_mem[chan] <= data; // (R8)
					`DEST_OFFSET: offset_mem[chan] <= data; // (R19)
					`DEST_GAIN: gain_mem[chan] <= data[13:1]; // (R20)
					default: input_mem[chan] <= step_value; // (R21)
				endcase
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			instr <= 24'h00_0000;
			chan <= 6'h00;
			grp <= 2'h0;
			idx <= 4'h0;
			busy_n <= 1'b1;
			interface_awake <= 1'b0;
			queue_full <= 1'b0;
			reg_write <= 1'b0;
			reg_channel <= 6'h00;
			reg_kind <= 2'b00;
			reg_value <= 14'h0000;
			outputs_to_ground_sense <= 1'b0;
		end else begin
			state <= next_state;
			queue_full <= q_full;
			reg_write <= 1'b0;
			// Busy also covers the cycle an instruction enters the queue
			busy_n <= !(q_not_empty || state == ST_RUN || push); // (R4)
			// Port sleeps once nothing is pending or arriving in parallel mode; serial mode keeps it awake
			if ((strobe_fall && !serial_mode) || ser_start) begin
				interface_awake <= 1'b1; // (R5)
			end else if (!q_not_empty && !push && state == ST_IDLE && strobe_b[0]
				&& sync_idle(serial_mode)) begin
				interface_awake <= 1'b0;
			end
			if (q_pop) begin
				instr <= q_head;
				chan <= 6'h00;
				grp <= 2'h0;
				idx <= 4'h0;
				outputs_to_ground_sense <= 1'b0;
			end else if (state == ST_RUN) begin
				chan <= chan + 6'd1;
				if (idx == `GROUP_SIZE_LAST) begin
					idx <= 4'h0;
					grp <= grp + 2'd1;
				end else begin
					idx <= idx + 4'd1;
				end
				if (soft_reset) begin
					outputs_to_ground_sense <= 1'b1; // (R22)
				end else if (chan_hit) begin
					reg_write <= 1'b1;
					reg_channel <= chan;
					reg_kind <= dest; // (R7)
					reg_value <= (dest == `DEST_SPECIAL) ? step_value :
						(dest == `DEST_GAIN) ? {1'b0, data[13:1]} : data;
				end
			end
		end
	end

	// Serial side counts as idle when not selected
	function sync_idle;
		input ser;
		begin
			sync_idle = !ser;
		end
	endfunction

endmodule
`default_nettype wire

// *** verif/dac_port_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dac_port_regs.vh"
module dac_port_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pins
	input wire logic port_choice_pin,
	input wire logic chain_enable_pin,
	input wire logic device_select_n,
	input wire logic load_strobe_n,
	input wire logic frame_sel_n,
	input wire logic shift_clk,
	input wire logic chain_out_line,
	// Status and results
	input wire logic busy_n,
	input wire logic interface_awake,
	input wire logic queue_full,
	input wire logic reg_write,
	input wire logic [5:0] reg_channel,
	input wire logic [1:0] reg_kind,
	input wire logic [13:0] reg_value,
	input wire logic outputs_to_ground_sense
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_write_while_busy: assert property (reg_write |-> !busy_n)
		else $error("register write while not busy");
	a_full_is_busy: assert property (queue_full |-> !busy_n)
		else $error("queue full while not busy");
	a_channel_range: assert property (reg_write |-> reg_channel < 6'd40)
		else $error("channel out of range");
	a_gain_upper: assert property (reg_write && reg_kind == `DEST_GAIN |-> !reg_value[13])
		else $error("gain value wider than 13 bits");
	a_soft_reset_quiet: assert property (outputs_to_ground_sense |-> !reg_write)
		else $error("write pulse during soft reset");
	a_wake_strobe: assert property ($fell(load_strobe_n) && !port_choice_pin |-> ##[1:6] interface_awake)
		else $error("no wake after strobe fall");
	a_wake_frame: assert property ($fell(frame_sel_n) && port_choice_pin |-> ##[1:6] interface_awake)
		else $error("no wake after frame fall");
	a_busy_on_load: assert property ($rose(load_strobe_n) && !device_select_n && !port_choice_pin
		&& !queue_full |-> ##[1:8] !busy_n)
		else $error("no busy after parallel load");
	a_standalone_quiet: assert property ((!chain_enable_pin)[*6] |-> !chain_out_line)
		else $error("chain output active in standalone");
	a_chain_on_rise: assert property (port_choice_pin && chain_enable_pin && $changed(chain_out_line)
		|-> $past(shift_clk))
		else $error("chain output moved on falling side");
endmodule
bind dac_host_write_port dac_port_checker chk (.clk_sys, .rst_n, .port_choice_pin,
	.chain_enable_pin, .device_select_n, .load_strobe_n, .frame_sel_n, .shift_clk,
	.chain_out_line, .busy_n, .interface_awake, .queue_full, .reg_write, .reg_channel,
	.reg_kind, .reg_value, .outputs_to_ground_sense);
`default_nettype wire

// *** verif/serial_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_host (
	// Link pins
	output logic frame_sel_n,
	output logic shift_clk,
	output logic serial_din,
	input wire logic chain_out_line
);
	logic [47:0] echo;
	initial begin
		frame_sel_n = 1'b1;
		shift_clk = 1'b1;
		serial_din = 1'b0;
		echo = '0;
	end
	// Burst of exactly n clocks, frame raised after the last one
	task automatic send(input logic [47:0] bits, input int n);
		frame_sel_n = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			serial_din = bits[i];
			#40 shift_clk = 1'b0;
			echo = {echo[46:0], chain_out_line};
			#40 shift_clk = 1'b1;
		end
		#40 frame_sel_n = 1'b1;
		// Released line must not look like held data
		serial_din = ~serial_din;
		// Frame must stay high long enough to be seen between bursts
		#80;
	endtask
endmodule
`default_nettype wire

// *** verif/dac_host_write_port_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module dac_host_write_port_test;
	logic clk_sys;
	logic rst_n;
	logic port_choice_pin;
	logic chain_enable_pin;
	logic device_select_n;
	logic load_strobe_n;
	logic dest_select_hi;
	logic dest_select_lo;
	logic [7:0] channel_address_lines;
	logic [13:0] data_word_lines;
	wire frame_sel_n, shift_clk, serial_din, chain_out_line;
	wire busy_n, interface_awake, queue_full, reg_write, outputs_to_ground_sense;
	wire [5:0] reg_channel;
	wire [1:0] reg_kind;
	wire [13:0] reg_value;
	logic [23:0] exp_q[$];
	int seed = 9773;
	int n_mismatch = 0;
	int checks_done = 0;
	int n;
	logic [13:0] d;
	logic [1:0] kd;
	logic acc;
	// Load, clamp high, step down 127, zero step, load, clamp low
	logic [15:0] tbl [6] = '{16'hfffc, 16'h0107, 16'h007f, 16'h0100, 16'hc005, 16'h0007};
	logic [13:0] res [6] = '{14'h3ffc, 14'h3fff, 14'h3f80, 14'h3f80, 14'h0005, 14'h0000};

	dac_host_write_port uut (.clk_sys, .rst_n, .port_choice_pin, .chain_enable_pin,
		.device_select_n, .load_strobe_n, .dest_select_hi, .dest_select_lo,
		.channel_address_lines, .data_word_lines, .frame_sel_n, .shift_clk, .serial_din,
		.chain_out_line, .busy_n, .interface_awake, .queue_full, .reg_write, .reg_channel,
		.reg_kind, .reg_value, .outputs_to_ground_sense);
	serial_host host (.frame_sel_n, .shift_clk, .serial_din, .chain_out_line);

	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic expect_w(input logic [5:0] ch, input logic [1:0] k, input logic [13:0] v);
		exp_q.push_back({2'b00, ch, k, v});
	endtask

	// Full flag read as it stood when the queue took the word
	task automatic pwrite(input logic [23:0] w, output logic ok);
		@(posedge clk_sys);
		#1 {dest_select_hi, dest_select_lo, channel_address_lines, data_word_lines} = w;
		device_select_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 load_strobe_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 load_strobe_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 ok = (queue_full !== 1'b1);
		repeat (1) @(posedge clk_sys);
		#1 device_select_n = 1'b1;
	endtask

	task automatic wait_idle;
		int i;
		repeat (12) @(posedge clk_sys);
		for (i = 0; i < 9000 && busy_n !== 1'b1; i++)
			@(posedge clk_sys);
		#1;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end

	always @(posedge clk_sys)
		if (reg_write === 1'b1)
			check("reg write", exp_q.size() ? exp_q.pop_front() : 24'hxx_xxxx,
				{2'b00, reg_channel, reg_kind, reg_value});

	initial begin
		rst_n = 1'b0;
		port_choice_pin = 1'b0;
		chain_enable_pin = 1'b0;
		device_select_n = 1'b1;
		load_strobe_n = 1'b1;
		{dest_select_hi, dest_select_lo, channel_address_lines, data_word_lines} = '0;
		repeat (16) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		for (int k = 0; k < 3; k++) begin
			d = $random(seed);
			kd = 2'(3 - k);
			expect_w(6'd15, kd, k == 2 ? {1'b0, d[13:1]} : d);
			expect_w(6'd25, kd, k == 2 ? {1'b0, d[13:1]} : d);
			pwrite({kd, 8'h65, d}, acc);
			check("busy", 24'h00_0000, {23'h0, busy_n});
			check("awake", 24'h00_0001, {23'h0, interface_awake});
		end
		wait_idle();
		check("awake", 24'h00_0000, {23'h0, interface_awake});
		$display("test parallel kinds done");
		for (int i = 0; i < 6; i++) begin
			expect_w(6'd3, tbl[i][15:14], res[i]);
			pwrite({tbl[i][15:14], 8'h13, tbl[i][13:0]}, acc);
		end
		pwrite({2'b00, 8'h00, 14'h3fff}, acc);
		wait_idle();
		check("ground sense", 24'h00_0001, {23'h0, outputs_to_ground_sense});
		expect_w(6'd3, 2'b00, 14'h0001);
		pwrite({2'b00, 8'h13, 14'h0101}, acc);
		wait_idle();
		check("ground sense", 24'h00_0000, {23'h0, outputs_to_ground_sense});
		$display("test step and soft reset done");
		port_choice_pin = 1'b1;
		repeat (4) @(posedge clk_sys);
		pwrite({2'b11, 8'h13, 14'h0aaa}, acc);
		check("busy", 24'h00_0001, {23'h0, busy_n});
		d = $random(seed);
		expect_w(6'd3, 2'b11, d);
		host.send({18'h0, 2'b11, 8'h13, d, 6'h2a}, 30);
		wait_idle();
		$display("test serial standalone done");
		chain_enable_pin = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 d = $random(seed);
		expect_w(6'd5, 2'b11, d);
		host.send({2'b11, 8'h25, 14'h1234, 2'b11, 8'h15, d}, 48);
		check("chain out", {2'b11, 8'h25, 14'h1234}, host.echo[23:0]);
		host.send(48'h12_3456, 20);
		wait_idle();
		$display("test serial chain done");
		port_choice_pin = 1'b0;
		chain_enable_pin = 1'b0;
		repeat (4) @(posedge clk_sys);
		n = 0;
		for (int i = 0; i < 400 && n < 4; i++) begin
			pwrite({2'b11, 8'h13, 14'(i)}, acc);
			if (acc)
				expect_w(6'd3, 2'b11, 14'(i));
			else
				n++;
		end
		check("dropped writes", 24'h00_0004, 24'(n));
		wait_idle();
		check("pending writes", 24'h00_0000, 24'(exp_q.size()));
		$display("test queue fill done");
		close_out();
	end
endmodule
`default_nettype wire
